// ### hw/gpcb_bank.sv
// APB configuration registers and pad control for pins 3 and 5 to 8
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
// Overview of operation
// [R1] Port select moves pin-3 config to secondary pad
// [R2] Decode {direction, enable} into pad mode
// [R3] Local value driven only in GPIO output
// [R4] Remote enable drives remote value as output
// [R5] Higher pin upper nibble, lower pin lower
// [R6] Pin-3 resets 0x2; upper bits read zero
// [R7] Pins 5 to 8 reset to zero
// [R8] Remote enable outranks local direction code
module gpcb_bank (
  input wire logic clk, // 10 MHz clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic ce, // Clock enable, freezes all state when low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [gpcb_pkg::ADDR_W-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte strobes
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire logic [gpcb_pkg::NPADS-1:0] remote_val, // Values from the remote serializer, per pad
  input wire logic [gpcb_pkg::NPADS-1:0] func_val, // Functional-mode output values, per pad
  input wire logic [gpcb_pkg::NPADS-1:0] pad_i, // Pad levels
  output logic [gpcb_pkg::NPADS-1:0] pad_o, // Pad output values
  output logic [gpcb_pkg::NPADS-1:0] pad_oe // Pad output enables
);
  logic [3:0] pin3_config_q;
  logic [7:0] pins5_6_config_q;
  logic [7:0] pins7_8_config_q;
  logic secondary_port_select_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [gpcb_pkg::NPADS-1:0] pad_in;
  logic [3:0] cfg_w [gpcb_pkg::NPADS];

  // Bus decode
  wire acc = psel & penable;
  wire take = acc & ~pready_q;
  wire done = acc & pready_q;
  wire hit_p3 = (paddr == gpcb_pkg::ADDR_PIN3);
  wire hit_p56 = (paddr == gpcb_pkg::ADDR_PINS56);
  wire hit_p78 = (paddr == gpcb_pkg::ADDR_PINS78);
  wire hit_sel = (paddr == gpcb_pkg::ADDR_PORTSEL);
  wire hit_in = (paddr == gpcb_pkg::ADDR_PADIN);
  wire hit = hit_p3 | hit_p56 | hit_p78 | hit_sel | hit_in;
  // Only the low byte holds data, so only its strobe matters
  wire wr = done & pwrite & pstrb[0];
  wire [7:0] rd_w = hit_p3 ? {4'h0, pin3_config_q} : // R6
                    hit_p56 ? pins5_6_config_q :
                    hit_p78 ? pins7_8_config_q :
                    hit_sel ? {7'h00, secondary_port_select_q} :
                    hit_in ? {2'h0, pad_in} : 8'h00;

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // One wait state: data and error are registered in the first access cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else if (ce) begin
      pready_q <= take;
      if (take) begin
        pslverr_q <= ~hit;
        prdata_q <= pwrite ? 32'h00000000 : {24'h000000, rd_w};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin3_config_q <= gpcb_pkg::RST_PIN3; // R6
      pins5_6_config_q <= gpcb_pkg::RST_PAIR; // R7
      pins7_8_config_q <= gpcb_pkg::RST_PAIR; // R7
      secondary_port_select_q <= gpcb_pkg::RST_SEL;
    end else if (ce && wr) begin
      if (hit_p3)
        pin3_config_q <= pwdata[3:0]; // R6
      if (hit_p56)
        pins5_6_config_q <= pwdata[7:0];
      if (hit_p78)
        pins7_8_config_q <= pwdata[7:0];
      if (hit_sel)
        secondary_port_select_q <= pwdata[0];
    end
  end

  // The pad not selected sits at the reset code, i.e. tri-stated
  assign cfg_w[gpcb_pkg::PAD_P3] = secondary_port_select_q ? gpcb_pkg::RST_PIN3 : pin3_config_q; // R1
  assign cfg_w[gpcb_pkg::PAD_S3] = secondary_port_select_q ? pin3_config_q : gpcb_pkg::RST_PIN3; // R1
  assign cfg_w[gpcb_pkg::PAD_5] = pins5_6_config_q[gpcb_pkg::HI_LSB-1:0]; // R5
  assign cfg_w[gpcb_pkg::PAD_6] = pins5_6_config_q[7:gpcb_pkg::HI_LSB]; // R5
  assign cfg_w[gpcb_pkg::PAD_7] = pins7_8_config_q[gpcb_pkg::HI_LSB-1:0]; // R5
  assign cfg_w[gpcb_pkg::PAD_8] = pins7_8_config_q[7:gpcb_pkg::HI_LSB]; // R5

  for (genvar k = 0; k < gpcb_pkg::NPADS; k++) begin : g_pad
    gpcb_pin_ctl u_pin (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .cfg(cfg_w[k]),
      .remote_val(remote_val[k]),
      .func_val(func_val[k]),
      .pad_i(pad_i[k]),
      .pad_o(pad_o[k]),
      .pad_oe(pad_oe[k]),
      .pad_in_q(pad_in[k])
    );
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Pad outputs are registered, so pad checks look one edge after the cause
  AST_SEL_SECONDARY: assert property ( // R1
    (ce && secondary_port_select_q
      && (pin3_config_q[gpcb_pkg::FLD_RMT] || !pin3_config_q[gpcb_pkg::FLD_DIR]))
      |=> (pad_oe[gpcb_pkg::PAD_S3] && !pad_oe[gpcb_pkg::PAD_P3]))
    else $error("pin-3 config not steered to secondary pad");

  AST_TRISTATE: assert property ( // R2
    (ce && !cfg_w[gpcb_pkg::PAD_5][gpcb_pkg::FLD_RMT]
      && gpcb_pkg::pin_mode(cfg_w[gpcb_pkg::PAD_5]) inside {gpcb_pkg::GPCB_TRISTATE, gpcb_pkg::GPCB_GPIO_IN})
      |=> !pad_oe[gpcb_pkg::PAD_5])
    else $error("pin 5 driven while tri-state or input");

  AST_FUNC_OUT: assert property ( // R2
    (ce && !cfg_w[gpcb_pkg::PAD_6][gpcb_pkg::FLD_RMT]
      && gpcb_pkg::pin_mode(cfg_w[gpcb_pkg::PAD_6]) == gpcb_pkg::GPCB_FUNC_OUT)
      |=> (pad_oe[gpcb_pkg::PAD_6] && pad_o[gpcb_pkg::PAD_6] == $past(func_val[gpcb_pkg::PAD_6])))
    else $error("pin 6 functional output wrong");

  AST_LOCAL_OUT: assert property ( // R3
    (ce && !cfg_w[gpcb_pkg::PAD_7][gpcb_pkg::FLD_RMT]
      && gpcb_pkg::pin_mode(cfg_w[gpcb_pkg::PAD_7]) == gpcb_pkg::GPCB_GPIO_OUT)
      |=> (pad_oe[gpcb_pkg::PAD_7]
        && pad_o[gpcb_pkg::PAD_7] == $past(cfg_w[gpcb_pkg::PAD_7][gpcb_pkg::FLD_VAL])))
    else $error("pin 7 local value not driven");

  AST_REMOTE_OUT: assert property ( // R4
    (ce && cfg_w[gpcb_pkg::PAD_8][gpcb_pkg::FLD_RMT])
      |=> (pad_oe[gpcb_pkg::PAD_8] && pad_o[gpcb_pkg::PAD_8] == $past(remote_val[gpcb_pkg::PAD_8])))
    else $error("pin 8 remote value not driven");

  AST_PAIR_LAYOUT: assert property ( // R5
    (ce && take && !pwrite && hit_p56)
      |=> (prdata[7:4] == cfg_w[gpcb_pkg::PAD_6] && prdata[3:0] == cfg_w[gpcb_pkg::PAD_5]))
    else $error("pins 5/6 read layout wrong");

  AST_PIN3_RESET: assert property ( // R6
    (!$past(rst_n) |-> (pin3_config_q == gpcb_pkg::RST_PIN3 && !pad_oe[gpcb_pkg::PAD_P3]))
      and ((ce && take && !pwrite && hit_p3) |=> prdata[31:4] == 28'h0000000))
    else $error("pin-3 reset value or reserved bits wrong");

  AST_PAIRS_RESET: assert property ( // R7
    !$past(rst_n) |-> (pins5_6_config_q == gpcb_pkg::RST_PAIR && pins7_8_config_q == gpcb_pkg::RST_PAIR))
    else $error("pins 5 to 8 reset value wrong");

  AST_REMOTE_WINS: assert property ( // R8
    (ce && cfg_w[gpcb_pkg::PAD_6][gpcb_pkg::FLD_RMT]
      && gpcb_pkg::pin_mode(cfg_w[gpcb_pkg::PAD_6]) inside {gpcb_pkg::GPCB_TRISTATE, gpcb_pkg::GPCB_GPIO_IN})
      |=> (pad_oe[gpcb_pkg::PAD_6] && pad_o[gpcb_pkg::PAD_6] == $past(remote_val[gpcb_pkg::PAD_6])))
    else $error("local code beat remote control on pin 6");

  AST_PRIMARY_WHEN_CLEAR: assert property ( // R1
    (ce && !secondary_port_select_q
      && (pin3_config_q[gpcb_pkg::FLD_RMT] || !pin3_config_q[gpcb_pkg::FLD_DIR]))
      |=> (pad_oe[gpcb_pkg::PAD_P3] && !pad_oe[gpcb_pkg::PAD_S3]))
    else $error("pin-3 config not on primary pad");

  AST_TRISTATE_P3: assert property ( // R2
    (ce && !secondary_port_select_q && !pin3_config_q[gpcb_pkg::FLD_RMT]
      && gpcb_pkg::pin_mode(pin3_config_q) == gpcb_pkg::GPCB_TRISTATE)
      |=> (!pad_oe[gpcb_pkg::PAD_P3] && !pad_oe[gpcb_pkg::PAD_S3]))
    else $error("pin 3 driven while tri-state");

  AST_LOCAL_OUT_P5: assert property ( // R3
    (ce && !cfg_w[gpcb_pkg::PAD_5][gpcb_pkg::FLD_RMT]
      && gpcb_pkg::pin_mode(cfg_w[gpcb_pkg::PAD_5]) == gpcb_pkg::GPCB_GPIO_OUT)
      |=> (pad_oe[gpcb_pkg::PAD_5]
        && pad_o[gpcb_pkg::PAD_5] == $past(cfg_w[gpcb_pkg::PAD_5][gpcb_pkg::FLD_VAL])))
    else $error("pin 5 local value not driven");

  AST_REMOTE_IGNORED: assert property ( // R4
    (ce && !cfg_w[gpcb_pkg::PAD_6][gpcb_pkg::FLD_RMT]
      && gpcb_pkg::pin_mode(cfg_w[gpcb_pkg::PAD_6]) inside {gpcb_pkg::GPCB_TRISTATE, gpcb_pkg::GPCB_GPIO_IN})
      |=> !pad_oe[gpcb_pkg::PAD_6])
    else $error("pin 6 driven with remote control off");

  AST_PAIR78_LAYOUT: assert property ( // R5
    (ce && take && !pwrite && hit_p78)
      |=> (prdata[7:4] == cfg_w[gpcb_pkg::PAD_8] && prdata[3:0] == cfg_w[gpcb_pkg::PAD_7]))
    else $error("pins 7/8 read layout wrong");

  AST_PADS_AFTER_RESET: assert property ( // R7
    (ce && !$past(rst_n)) |=> (pad_oe[gpcb_pkg::PAD_8:gpcb_pkg::PAD_5] == 4'hF))
    else $error("pins 5 to 8 not in functional output after reset");

  // Bus checks: a stuck pready would hang every master
  AST_READY_PULSE: assert property (
    (ce && pready) |=> !pready)
    else $error("pready high for more than one cycle");

  AST_UNMAPPED_ERR: assert property (
    (ce && take && !hit) |=> (pready && pslverr))
    else $error("unmapped access not flagged");

  AST_WRITE_NEEDS_STROBE: assert property (
    (ce && done && pwrite && !pstrb[0] && hit_sel)
      |=> $stable(secondary_port_select_q))
    else $error("write without low-byte strobe took effect");
endmodule // gpcb_bank

// ### hw/gpcb_pin_ctl.sv
// One pad: direction and value selection plus input synchroniser
`timescale 1ns/1ps
module gpcb_pin_ctl (
  input wire logic clk, // 10 MHz clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic ce, // Clock enable
  input wire logic [3:0] cfg, // Value, remote, direction, enable
  input wire logic remote_val, // Value from the remote serializer
  input wire logic func_val, // Functional-mode output value
  input wire logic pad_i, // Pad level, asynchronous
  output logic pad_o, // Pad output value
  output logic pad_oe, // Pad output enable, high drives
  output logic pad_in_q // Synchronised pad level
);
  gpcb_pkg::gpcb_mode_t mode;
  logic remote;
  logic oe_d;
  logic o_d;
  logic sync1_q;

  assign mode = gpcb_pkg::pin_mode(cfg); // R2
  assign remote = cfg[gpcb_pkg::FLD_RMT];
  // Remote control overrides the local code entirely
  assign oe_d = remote | (mode == gpcb_pkg::GPCB_FUNC_OUT) | (mode == gpcb_pkg::GPCB_GPIO_OUT); // R2 R4 R8
  assign o_d = remote ? remote_val : // R4 R8
               (mode == gpcb_pkg::GPCB_GPIO_OUT) ? cfg[gpcb_pkg::FLD_VAL] : // R3
               (mode == gpcb_pkg::GPCB_FUNC_OUT) ? func_val : 1'b0;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pad_oe <= 1'b0;
      pad_o <= 1'b0;
      sync1_q <= 1'b0;
      pad_in_q <= 1'b0;
    end else if (ce) begin
      pad_oe <= oe_d;
      pad_o <= o_d;
      sync1_q <= pad_i;
      pad_in_q <= sync1_q;
    end
  end
endmodule // gpcb_pin_ctl

// ### hw/gpcb_pkg.sv
// Shared constants and types for the pin configuration bank
package gpcb_pkg;
  localparam int ADDR_W = 8;
  localparam int NPADS = 6;
  // Register indices; the byte address is four times the index
  localparam logic [7:0] IDX_PIN3 = 8'h1F;
  localparam logic [7:0] IDX_PINS56 = 8'h20;
  localparam logic [7:0] IDX_PINS78 = 8'h21;
  localparam logic [7:0] IDX_PORTSEL = 8'h30;
  localparam logic [7:0] IDX_PADIN = 8'h31;
  localparam logic [7:0] ADDR_PIN3 = {IDX_PIN3[5:0], 2'b00};
  localparam logic [7:0] ADDR_PINS56 = {IDX_PINS56[5:0], 2'b00};
  localparam logic [7:0] ADDR_PINS78 = {IDX_PINS78[5:0], 2'b00};
  localparam logic [7:0] ADDR_PORTSEL = {IDX_PORTSEL[5:0], 2'b00};
  localparam logic [7:0] ADDR_PADIN = {IDX_PADIN[5:0], 2'b00};
  // Nibble field positions and the upper nibble base
  localparam int FLD_VAL = 3;
  localparam int FLD_RMT = 2;
  localparam int FLD_DIR = 1;
  localparam int FLD_EN = 0;
  localparam int HI_LSB = 4;
  // Values after reset
  localparam logic [3:0] RST_PIN3 = 4'h2;
  localparam logic [7:0] RST_PAIR = 8'h00;
  localparam logic RST_SEL = 1'b0;
  // Pad indices
  localparam int PAD_P3 = 0;
  localparam int PAD_S3 = 1;
  localparam int PAD_5 = 2;
  localparam int PAD_6 = 3;
  localparam int PAD_7 = 4;
  localparam int PAD_8 = 5;
  // Pad mode, coded as {direction, enable}
  typedef enum logic [1:0] {
    GPCB_FUNC_OUT = 2'b00,
    GPCB_GPIO_OUT = 2'b01,
    GPCB_TRISTATE = 2'b10,
    GPCB_GPIO_IN = 2'b11
  } gpcb_mode_t;

  function automatic gpcb_mode_t pin_mode(input logic [3:0] cfg);
    pin_mode = gpcb_mode_t'({cfg[FLD_DIR], cfg[FLD_EN]});
  endfunction
endpackage

// ### tb/gpcb_remote_model.sv
// Remote serializer model: presents link-received pin values to the bank
`timescale 1ns/1ps
module gpcb_remote_model (
  input wire logic clk, // 10 MHz clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic [5:0] send, // Values the far side transmits
  output logic [5:0] remote_val // Received values, one per pad
);
  // Values arrive one cycle after sending, as a link register would give them
  always_ff @(posedge clk) begin
    if (!rst_n) remote_val <= 6'h00;
    else remote_val <= send;
  end
endmodule // gpcb_remote_model

// ### tb/gpio_pin_config_bank_tb_top.sv
// Register and pad tests for the pin configuration bank
`timescale 1ns/1ps
module gpio_pin_config_bank_tb_top;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err;
  logic [5:0] send = 6'h00, remote_val, pad_o, pad_oe;
  logic [5:0] func_val = 6'h2A;
  logic ce = 1'b1;
  logic [3:0] pstrb = 4'hF;
  int fail_count = 0, checks_done = 0;
  always #50 clk = ~clk;
  gpcb_remote_model i_rem (.clk(clk), .rst_n(rst_n), .send(send), .remote_val(remote_val));
  gpcb_bank i_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .remote_val(remote_val), .func_val(func_val), .pad_i(6'h15), .pad_o(pad_o), .pad_oe(pad_oe));
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Holds the request until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // Pads settle one cycle after the release cycle of a write
  task automatic wr_settle(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    repeat (3) @(posedge clk);
  endtask
  initial begin
    repeat (2000) @(posedge clk);
    fail_count++;
    conclude();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk({26'h0, pad_oe}, 32'h3C);
    chk({26'h0, pad_o}, 32'h28);
    rd_chk(gpcb_pkg::ADDR_PIN3, 32'h2);
    rd_chk(gpcb_pkg::ADDR_PINS56, 32'h0);
    rd_chk(gpcb_pkg::ADDR_PINS78, 32'h0);
    apb(1'b1, gpcb_pkg::ADDR_PIN3, 32'hFF);
    rd_chk(gpcb_pkg::ADDR_PIN3, 32'h0F);
    $display("test reset_values done");
    for (int c = 0; c < 4; c++) begin
      wr_settle(gpcb_pkg::ADDR_PINS56, 32'h08 | c);
      chk({31'h0, pad_oe[2]}, {31'h0, c < 2});
      chk({31'h0, pad_o[2]}, {31'h0, c == 1});
    end
    func_val <= 6'h15;
    repeat (3) @(posedge clk);
    chk({30'h0, pad_oe[3:2]}, 32'h2);
    chk({31'h0, pad_o[3]}, 32'h0);
    $display("test mode_decode done");
    send <= 6'h08;
    wr_settle(gpcb_pkg::ADDR_PINS56, 32'h62);
    chk({30'h0, pad_oe[3:2]}, 32'h2);
    chk({31'h0, pad_o[3]}, 32'h1);
    send <= 6'h00;
    repeat (3) @(posedge clk);
    chk({31'h0, pad_o[3]}, 32'h0);
    send <= 6'h08;
    wr_settle(gpcb_pkg::ADDR_PINS56, 32'h22);
    chk({31'h0, pad_oe[3]}, 32'h0);
    apb(1'b1, gpcb_pkg::ADDR_PINS78, 32'h59);
    rd_chk(gpcb_pkg::ADDR_PINS78, 32'h59);
    send <= 6'h20;
    repeat (3) @(posedge clk);
    chk({30'h0, pad_oe[5:4]}, 32'h3);
    chk({30'h0, pad_o[5:4]}, 32'h3);
    $display("test remote_control done");
    ce <= 1'b0;
    send <= 6'h00;
    repeat (3) @(posedge clk);
    chk({31'h0, pad_o[5]}, 32'h1);
    ce <= 1'b1;
    repeat (3) @(posedge clk);
    chk({31'h0, pad_o[5]}, 32'h0);
    $display("test clock_enable done");
    apb(1'b1, gpcb_pkg::ADDR_PORTSEL, 32'h1);
    rd_chk(gpcb_pkg::ADDR_PORTSEL, 32'h1);
    wr_settle(gpcb_pkg::ADDR_PIN3, 32'h9);
    chk({30'h0, pad_oe[1:0]}, 32'h2);
    chk({31'h0, pad_o[1]}, 32'h1);
    apb(1'b1, gpcb_pkg::ADDR_PORTSEL, 32'h0);
    repeat (3) @(posedge clk);
    chk({30'h0, pad_oe[1:0]}, 32'h1);
    pstrb <= 4'hE;
    apb(1'b1, gpcb_pkg::ADDR_PORTSEL, 32'h1);
    pstrb <= 4'hF;
    rd_chk(gpcb_pkg::ADDR_PORTSEL, 32'h0);
    rd_chk(gpcb_pkg::ADDR_PADIN, 32'h15);
    chk({31'h0, err}, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    $display("test port_select done");
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(gpcb_pkg::ADDR_PIN3, 32'h2);
    rd_chk(gpcb_pkg::ADDR_PINS56, 32'h0);
    rd_chk(gpcb_pkg::ADDR_PINS78, 32'h0);
    rd_chk(gpcb_pkg::ADDR_PORTSEL, 32'h0);
    chk({26'h0, pad_oe}, 32'h3C);
    chk({26'h0, pad_o}, 32'h14);
    $display("test mid_reset done");
    conclude();
  end
endmodule // gpio_pin_config_bank_tb_top
